// ---- frt_pkg.sv ----
package frt_pkg;

    // apb byte addresses of the table dwords and of the control and status registers
    localparam logic [7:0] FRT_TBL_FIRST  = 8'h30;
    localparam logic [7:0] FRT_TBL_LAST   = 8'h48;
    localparam int         FRT_TBL_WORDS  = 7;
    localparam int         FRT_IDX_W      = 3;
    localparam logic [7:0] FRT_CTRL_ADDR  = 8'h80;
    localparam logic [7:0] FRT_STAT_ADDR  = 8'h84;

    // read mode opcodes and entries
    localparam logic [7:0] FRT_OP_DUAL_OUT = 8'h3b;
    localparam logic [7:0] FRT_OP_QUAD_OUT = 8'h6b;
    localparam logic [7:0] FRT_OP_DUAL_IO  = 8'hbb;
    localparam logic [7:0] FRT_OP_QUAD_IO  = 8'heb;
    localparam logic [7:0] FRT_OP_NONE     = 8'hff;
    localparam logic [7:0] FRT_OP_EXIT     = 8'hff;  // continuous_read_exit_command

    localparam logic [4:0] FRT_DUMMY_8    = 5'h08;
    localparam logic [4:0] FRT_DUMMY_4    = 5'h04;
    localparam logic [4:0] FRT_DUMMY_0    = 5'h00;
    localparam logic [2:0] FRT_MODE_0     = 3'h0;
    localparam logic [2:0] FRT_MODE_2     = 3'h2;
    localparam logic [2:0] FRT_MODE_4     = 3'h4;
    localparam logic [1:0] FRT_ADDR_BYTES = 2'h0;
    localparam logic       FRT_DTR        = 1'h0;
    localparam logic [1:0] FRT_SEL_KEEP   = 2'h2;    // continuous_read_select_bits value

    // table bytes held below the window
    localparam logic [7:0] FRT_B30 = 8'he5;
    localparam logic [7:0] FRT_B31 = 8'h20;
    localparam logic [31:0] FRT_DENSITY_DEF = 32'h007fffff;

    // dword 30h: byte 32h is the capability byte, 33h unused
    localparam logic [31:0] FRT_W30 = {8'hff, 1'h1, 1'h1, 1'h1, 1'h1, FRT_DTR,
                                       FRT_ADDR_BYTES, 1'h1, FRT_B31, FRT_B30};
    localparam logic [31:0] FRT_W38 = {FRT_OP_QUAD_OUT, FRT_MODE_0, FRT_DUMMY_8,
                                       FRT_OP_QUAD_IO, FRT_MODE_2, FRT_DUMMY_4};
    localparam logic [31:0] FRT_W3C = {FRT_OP_DUAL_IO, FRT_MODE_4, FRT_DUMMY_0,
                                       FRT_OP_DUAL_OUT, FRT_MODE_0, FRT_DUMMY_8};
    localparam logic [31:0] FRT_W40 = {24'hffffff, 3'h7, 1'h0, 3'h7, 1'h0};
    localparam logic [31:0] FRT_W44 = {FRT_OP_NONE, FRT_MODE_0, FRT_DUMMY_0, 16'hffff};
    localparam logic [31:0] FRT_W48 = {8'hff, FRT_MODE_0, FRT_DUMMY_0, 16'hffff};

    // control and status field layout
    localparam int FRT_CTRL_OP_LSB   = 0;
    localparam int FRT_CTRL_MODE_LSB = 8;
    localparam int FRT_SEL_LSB       = 4;

    typedef enum logic { FRT_CMD_NORMAL, FRT_CMD_CONT } frt_cmd_t;

    typedef struct packed {
        logic [31:0] rdata;
    } frt_rom_t;

    typedef struct packed {
        frt_cmd_t    cmd;
        logic [7:0]  cur_op;
        logic [7:0]  mode;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } frt_state_t;

    function automatic logic frt_tbl_hit(input logic [7:0] a);
        return (a >= FRT_TBL_FIRST) && (a <= FRT_TBL_LAST) && (a[1:0] == 2'h0);
    endfunction : frt_tbl_hit

endpackage : frt_pkg

// ---- frt_rom.sv ----
`timescale 1ns/1ps
module frt_rom
    import frt_pkg::*;
#(
    parameter logic [31:0] DENSITY = FRT_DENSITY_DEF
) (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // read port
    input  wire logic [FRT_IDX_W-1:0] idx,
    output logic      [31:0]          rdata
);

    frt_rom_t st_q;
    frt_rom_t st_d;

    always_comb begin
        st_d = st_q;
        case (idx)
            3'h0:    st_d.rdata = FRT_W30;
            3'h1:    st_d.rdata = DENSITY;
            3'h2:    st_d.rdata = FRT_W38;
            3'h3:    st_d.rdata = FRT_W3C;
            3'h4:    st_d.rdata = FRT_W40;
            3'h5:    st_d.rdata = FRT_W44;
            3'h6:    st_d.rdata = FRT_W48;
            default: st_d.rdata = 32'hffffffff;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;

endmodule : frt_rom

// ---- frt_table.sv ----
`timescale 1ns/1ps
module frt_table
    import frt_pkg::*;
#(
    parameter logic [31:0] DENSITY = FRT_DENSITY_DEF
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    ////////////////////////////////////////////////////////////////////////////
    frt_state_t           st_q;
    frt_state_t           st_d;
    logic [31:0]          rom_data;
    logic [7:0]           rel_addr;
    logic [FRT_IDX_W-1:0] rom_idx;
    logic                 access;
    logic                 done;
    logic [7:0]           wr_op;
    logic [7:0]           wr_mode;
    logic                 keep_sel;

    assign rel_addr = paddr - FRT_TBL_FIRST;
    assign rom_idx  = rel_addr[FRT_IDX_W+1:2];
    // pready is registered, so every transfer costs exactly one wait state
    assign access   = psel && penable && !st_q.pready;
    assign done     = psel && penable && st_q.pready;
    assign wr_op    = pwdata[FRT_CTRL_OP_LSB +: 8];
    assign wr_mode  = pwdata[FRT_CTRL_MODE_LSB +: 8];
    // only the select bits matter; the other mode bits are don't care
    assign keep_sel = (wr_mode[FRT_SEL_LSB +: 2] == FRT_SEL_KEEP);

    // rom data is registered, so the address from setup is ready in access
    frt_rom #(
        .DENSITY (DENSITY)
    ) u_rom (
        .pclk    (pclk),
        .presetn (presetn),
        .idx     (rom_idx),
        .rdata   (rom_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d        = st_q;
        st_d.pready = access;
        if (access) begin
            st_d.pslverr = 1'b0;
            st_d.prdata  = 32'h0;
            if (!pwrite) begin
                if (frt_tbl_hit(paddr)) begin
                    st_d.prdata = rom_data;
                end else if (paddr == FRT_STAT_ADDR) begin
                    st_d.prdata = {8'h0, st_q.mode, st_q.cur_op, 7'h0,
                                   st_q.cmd == FRT_CMD_CONT};
                end else if (paddr != FRT_CTRL_ADDR) begin
                    st_d.pslverr = 1'b1;
                end
            end else if (!frt_tbl_hit(paddr) && paddr != FRT_CTRL_ADDR) begin
                // writes to the table are accepted and dropped; others, except to the control register, are errors
                st_d.pslverr = 1'b1;
            end
        end
        if (done && pwrite && paddr == FRT_CTRL_ADDR) begin
            case (st_q.cmd)
                FRT_CMD_NORMAL: begin
                    if (wr_op == FRT_OP_DUAL_IO || wr_op == FRT_OP_QUAD_IO) begin
                        st_d.cur_op = wr_op;
                        st_d.mode   = wr_mode;
                        if (keep_sel) begin
                            st_d.cmd = FRT_CMD_CONT;
                        end
                    end
                end
                FRT_CMD_CONT: begin
                    if (wr_op == FRT_OP_EXIT) begin
                        st_d.cmd = FRT_CMD_NORMAL;
                    end else begin
                        st_d.mode = wr_mode;
                        if (!keep_sel) begin
                            st_d.cmd = FRT_CMD_NORMAL;
                        end
                    end
                end
                default: st_d.cmd = FRT_CMD_NORMAL;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q     <= '0;
            st_q.cmd <= FRT_CMD_NORMAL;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata  = st_q.prdata;
    assign pready  = st_q.pready;
    assign pslverr = st_q.pslverr;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rd_done;
    logic ctrl_wr;
    assign rd_done = done && !pwrite;
    assign ctrl_wr = done && pwrite && paddr == FRT_CTRL_ADDR;

    // table words: every completed table read except dword 34h is held against the constants
    a_dual_out_entry: assert property (rd_done && paddr == 8'h3c |->
        prdata[15:0] == {FRT_OP_DUAL_OUT, FRT_MODE_0, FRT_DUMMY_8})
        else $error("dual output entry wrong");

    a_quad_out_entry: assert property (rd_done && paddr == 8'h38 |->
        prdata[31:16] == 16'h6b08)
        else $error("quad output entry wrong");

    a_dual_io_entry: assert property (rd_done && paddr == 8'h3c |->
        prdata[31:16] == 16'hbb80)
        else $error("dual io entry wrong");

    a_quad_io_entry: assert property (rd_done && paddr == 8'h38 |->
        prdata[15:0] == 16'heb44)
        else $error("quad io entry wrong");

    a_dtr_flag_zero: assert property (rd_done && paddr == 8'h30 |->
        !prdata[19] && !pslverr)
        else $error("dtr flag set");

    a_addr_byte_field: assert property (rd_done && paddr == 8'h30 |->
        prdata[18:17] == 2'b00 && prdata[23:20] == 4'hf)
        else $error("address byte field wrong");

    a_two_two_two: assert property (rd_done && paddr == 8'h44 |->
        prdata[31:16] == 16'hff00)
        else $error("2-2-2 entry wrong");

    a_quad_cmd_none: assert property (rd_done && paddr == 8'h48 |->
        prdata[20:16] == 5'h00 && prdata[23:21] == 3'h0 && prdata[31:24] == 8'hff)
        else $error("4-4-4 wait states wrong");

    a_unused_ones: assert property (rd_done && paddr == 8'h40 |->
        prdata == 32'hffffffee)
        else $error("unused bits not ones");

    a_table_no_err: assert property (rd_done && frt_tbl_hit(paddr) |->
        !pslverr)
        else $error("table read flagged as error");

    a_write_ignored: assert property (done && pwrite && frt_tbl_hit(paddr) |->
        !pslverr && prdata == 32'h0 ##1 $stable(st_q.cmd) && $stable(st_q.mode))
        else $error("table write not ignored");

    ////////////////////////////////////////////////////////////////////////////
    // opcode-less read state
    a_cont_enter: assert property (done && pwrite && paddr == FRT_CTRL_ADDR &&
        st_q.cmd == FRT_CMD_NORMAL && wr_op == FRT_OP_QUAD_IO && keep_sel
        |=> st_q.cmd == FRT_CMD_CONT ##1 $stable(st_q.cur_op))
        else $error("continuous read not entered");

    a_dual_io_enter: assert property (ctrl_wr && st_q.cmd == FRT_CMD_NORMAL &&
        wr_op == FRT_OP_DUAL_IO && keep_sel |=> st_q.cmd == FRT_CMD_CONT &&
        st_q.cur_op == FRT_OP_DUAL_IO)
        else $error("dual io continuous read not entered");

    a_cont_leave: assert property (ctrl_wr && st_q.cmd == FRT_CMD_CONT &&
        wr_op != FRT_OP_EXIT && !keep_sel |=> st_q.cmd == FRT_CMD_NORMAL)
        else $error("continuous read not left");

    a_normal_ignore: assert property (ctrl_wr && st_q.cmd == FRT_CMD_NORMAL &&
        wr_op != FRT_OP_DUAL_IO && wr_op != FRT_OP_QUAD_IO |=>
        st_q.cmd == FRT_CMD_NORMAL && $stable(st_q.cur_op) && $stable(st_q.mode))
        else $error("other opcode changed read state");

    a_cont_exit: assert property (done && pwrite && paddr == FRT_CTRL_ADDR &&
        st_q.cmd == FRT_CMD_CONT && wr_op == FRT_OP_EXIT |=> st_q.cmd == FRT_CMD_NORMAL)
        else $error("exit command ignored");

    a_exit_keeps_mode: assert property (ctrl_wr && st_q.cmd == FRT_CMD_CONT &&
        wr_op == FRT_OP_EXIT |=> $stable(st_q.mode) && $stable(st_q.cur_op))
        else $error("exit command changed mode");

    ////////////////////////////////////////////////////////////////////////////
    // bus timing: the registered answer always gives one wait state
    a_answer_time: assert property ($rose(psel && penable) |-> !pready ##1 pready)
        else $error("answer not one wait state");

    c_table_read: cover property (rd_done && frt_tbl_hit(paddr));
    c_cont_entry: cover property (st_q.cmd == FRT_CMD_NORMAL ##1 st_q.cmd == FRT_CMD_CONT);
    c_cont_leave: cover property (st_q.cmd == FRT_CMD_CONT ##1 st_q.cmd == FRT_CMD_NORMAL);
    c_bad_addr:   cover property (done && pslverr);
    c_exit_cmd:   cover property (ctrl_wr && st_q.cmd == FRT_CMD_CONT && wr_op == FRT_OP_EXIT);

endmodule : frt_table

// ---- frt_host_model.sv ----
`timescale 1ns/1ps
module frt_host_model
    import frt_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // waits stays negative when the slave never answers
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output int waits);
        waits = -1;
        rd    = 32'h0;
        err   = 1'b1;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd    = prdata;
                err   = pslverr;
                waits = i;
                break;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rd_mode(input logic [7:0] op, input logic [7:0] mode);
        logic [31:0] rd;
        logic        err;
        int          w;
        xfer(1'b1, FRT_CTRL_ADDR, {16'h0, mode, op}, rd, err, w);
    endtask : rd_mode

    task automatic exit_cont();
        rd_mode(FRT_OP_EXIT, 8'h00);
    endtask : exit_cont
endmodule : frt_host_model

// ---- flash_read_mode_parameter_table_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module flash_read_mode_parameter_table_tb;
    import frt_pkg::*;
    localparam logic [31:0] DENS = 32'h007fffff;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          num_errors = 0;
    int          cmp_count  = 0;

    always #25 pclk = ~pclk;

    frt_table #(.DENSITY(DENS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    frt_host_model host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic xerr, output logic [31:0] rd);
        logic err;
        int   waits;
        host.xfer(w, a, d, rd, err, waits);
        if (waits < 0) begin
            num_errors++;
            close_out();
        end else begin
            `CHK(waits, 1)
            `CHK(err, xerr)
            if (w) begin
                `CHK(rd, 32'h0)
            end
        end
    endtask : bus

    task automatic t_table();
        logic [31:0] rd;
        bus(1'b0, 8'h30, 32'h0, 1'b0, rd);
        `CHK(rd[19], 1'b0)
        `CHK(rd[18:17], 2'b00)
        `CHK({rd[31:20], rd[16]}, 13'h1fff)
        bus(1'b0, 8'h34, 32'h0, 1'b0, rd);
        `CHK(rd, DENS)
        bus(1'b0, 8'h38, 32'h0, 1'b0, rd);
        `CHK(rd[15:0], {8'heb, 3'b010, 5'b00100})
        `CHK(rd[31:16], {8'h6b, 3'b000, 5'b01000})
        bus(1'b0, 8'h3c, 32'h0, 1'b0, rd);
        `CHK(rd[15:0], {8'h3b, 3'b000, 5'b01000})
        `CHK(rd[31:16], {8'hbb, 3'b100, 5'b00000})
        bus(1'b0, 8'h40, 32'h0, 1'b0, rd);
        `CHK(rd, 32'hffffffee)
        bus(1'b0, 8'h44, 32'h0, 1'b0, rd);
        `CHK(rd, {8'hff, 3'b000, 5'b00000, 16'hffff})
        bus(1'b0, 8'h48, 32'h0, 1'b0, rd);
        `CHK(rd[20:0], {5'b00000, 16'hffff})
        $display("table test done");
    endtask : t_table

    task automatic t_writes();
        logic [31:0] rd;
        for (int a = 'h30; a <= 'h48; a += 4) begin
            bus(1'b1, 8'(a), 32'h0, 1'b0, rd);
        end
        bus(1'b0, 8'h38, 32'h0, 1'b0, rd);
        `CHK(rd, 32'h6b08eb44)
        bus(1'b0, 8'h40, 32'h0, 1'b0, rd);
        `CHK(rd, 32'hffffffee)
        bus(1'b0, 8'h4c, 32'h0, 1'b1, rd);
        `CHK(rd, 32'h0)
        bus(1'b0, 8'h32, 32'h0, 1'b1, rd);
        bus(1'b1, FRT_STAT_ADDR, 32'h1, 1'b1, rd);
        bus(1'b0, FRT_CTRL_ADDR, 32'h0, 1'b0, rd);
        `CHK(rd, 32'h0)
        $display("write and map test done");
    endtask : t_writes

    task automatic stat(input logic [7:0] op, input logic [7:0] m, input logic c);
        logic [31:0] rd;
        bus(1'b0, FRT_STAT_ADDR, 32'h0, 1'b0, rd);
        `CHK(rd, {8'h00, m, op, 7'h00, c})
    endtask : stat

    task automatic t_cont();
        logic [31:0] rd;
        host.rd_mode(8'hbb, 8'h20);
        stat(8'hbb, 8'h20, 1'b1);
        host.rd_mode(8'heb, 8'h00);
        bus(1'b0, FRT_STAT_ADDR, 32'h0, 1'b0, rd);
        `CHK({rd[23:16], rd[0]}, 9'h000)
        host.rd_mode(8'heb, 8'h30);
        stat(8'heb, 8'h30, 1'b0);
        host.rd_mode(8'heb, 8'ha5);
        stat(8'heb, 8'ha5, 1'b1);
        host.exit_cont();
        stat(8'heb, 8'ha5, 1'b0);
        host.rd_mode(FRT_OP_DUAL_OUT, 8'h20);
        stat(8'heb, 8'ha5, 1'b0);
        $display("continuous read test done");
    endtask : t_cont

    task automatic t_reset();
        host.rd_mode(FRT_OP_DUAL_IO, 8'h20);
        stat(FRT_OP_DUAL_IO, 8'h20, 1'b1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        stat(8'h00, 8'h00, 1'b0);
        $display("reset test done");
    endtask : t_reset

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_table();
        t_writes();
        t_cont();
        t_reset();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        close_out();
    end
endmodule : flash_read_mode_parameter_table_tb
